// ===== rtl/csm_regs.vh
// register map, field positions, reset values and timing counts of the clock control block
`ifndef CSM_REGS_VH
`define CSM_REGS_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define CSM_ADDR_GATE_TWO      32'h40000034
`define CSM_ADDR_SRC_CTRL      32'h40000040
`define CSM_ADDR_SYS_SEL       32'h40000044
`define CSM_ADDR_MONITOR       32'h40000048

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define CSM_GATE_TWO_RST       32'h00000101
`define CSM_GATE_TWO_MASK      32'h00330f33
`define CSM_SRC_CTRL_RST       8'h20
`define CSM_SRC_CTRL_MASK      8'hbf
`define CSM_SYS_SEL_RST        8'h00
`define CSM_SYS_SEL_MASK       8'h07
`define CSM_MON_CTRL_RST       16'h0000
`define CSM_MON_CTRL_MASK      16'h8ccc

// ****************************************************************
// clock source control fields
// ****************************************************************
`define CSM_SUB_EN_BIT         7
`define CSM_RING_EN_BIT        5
`define CSM_RING_DIV_BIT       4
`define CSM_IRC_EN_BIT         3
`define CSM_IRC_DIV_BIT        2
`define CSM_XTAL_EN_BIT        1
`define CSM_XTAL_DIV_BIT       0

// ****************************************************************
// system clock select fields
// ****************************************************************
`define CSM_PLL_REF_BIT        2
`define CSM_MCLK_SEL_HI        1
`define CSM_MCLK_SEL_LO        0
`define CSM_MCLK_RING          2'b00

// ****************************************************************
// clock monitor fields
// ****************************************************************
`define CSM_REC_DIS_BIT        15
`define CSM_SUB_WATCH_BIT      11
`define CSM_SUB_IE_BIT         10
`define CSM_SUB_FAIL_BIT       9
`define CSM_SUB_RUN_BIT        8
`define CSM_MAIN_WATCH_BIT     7
`define CSM_MAIN_IE_BIT        6
`define CSM_MAIN_FAIL_BIT      5
`define CSM_MAIN_RUN_BIT       4
`define CSM_XTAL_WATCH_BIT     3
`define CSM_XTAL_IE_BIT        2
`define CSM_XTAL_FAIL_BIT      1
`define CSM_XTAL_RUN_BIT       0

// ****************************************************************
// bus answers and watch window
// ****************************************************************
`define CSM_RESP_OKAY          2'b00
`define CSM_RESP_SLVERR        2'b10
`define CSM_WATCH_WINDOW       4'd8
`define CSM_WATCH_ONE          4'd1

`endif

// ===== rtl/csm_clk_watch.v
// edge watchdog for one monitored oscillator, timed by ring oscillator edges
`include "csm_regs.vh"

module csm_clk_watch (
   input  wire clk_sys,
   input  wire reset_n,
   input  wire watch_clk,
   input  wire ring_tick,
   input  wire watch_en,
   output reg  running_r,
   output reg  fail_pulse_r
);

   reg       sync1_r;
   reg       sync2_r;
   reg       sync3_r;
   reg [3:0] quiet_cnt_r;
   wire      edge_seen;

   // ****************************************************************
   // synchroniser and edge detect
   // ****************************************************************
   // a clock faster than half of clk_sys aliases; only slow sources are judged exactly
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end else begin
         sync1_r <= watch_clk;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   assign edge_seen = sync2_r ^ sync3_r;

   // ****************************************************************
   // quiet window counter
   // ****************************************************************
   // status holds 1 while disabled so a read matches the reset value
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         quiet_cnt_r  <= 4'd0;
         running_r    <= 1'b1;
         fail_pulse_r <= 1'b0;
      end else begin
         fail_pulse_r <= 1'b0;
         if (!watch_en) begin
            quiet_cnt_r <= 4'd0;
            running_r   <= 1'b1;
         end else if (edge_seen) begin
            quiet_cnt_r <= 4'd0;
            running_r   <= 1'b1;                                      // RQ11
         end else if (ring_tick && quiet_cnt_r != `CSM_WATCH_WINDOW) begin
            quiet_cnt_r <= quiet_cnt_r + `CSM_WATCH_ONE;
            if (quiet_cnt_r == `CSM_WATCH_WINDOW - `CSM_WATCH_ONE) begin
               running_r    <= 1'b0;                                  // RQ17
               fail_pulse_r <= running_r;                             // RQ17
            end
         end
      end
   end

endmodule // csm_clk_watch

// ===== rtl/csm_clock_ctrl.v
// clock source select, peripheral clock gating and clock monitor with an AXI4-Lite register slave
// How it works
// RQ1: each set bit of the peripheral gate register drives the clock enable of its peripheral.
// RQ2: the gate register holds ADC at 21:20, motor PWM at 17:16, UART at 11:8, I2C at 5:4 and SPI at 1:0.
// RQ3: bit 7 of the source control register switches the sub crystal on or off.
// RQ4: ring field 5:4 stops on 0X, runs on 10 and runs divided by two on 11.
// RQ5: internal RC field 3:2 stops on 0X, runs on 10 and runs divided by two on 11.
// RQ6: crystal field 1:0 stops on 0X, runs on 10 and runs divided by two on 11.
// RQ7: bit 2 of the select register takes the PLL reference from the RC source on 0, the crystal on 1.
// RQ8: main select 1:0 takes the ring source on 0X, the PLL bypass on 10 and the PLL output on 11.
// RQ9: software keeps both RC and crystal running before choosing the crystal as PLL reference.
// RQ10: the three running bits mean something only while their watch enable is set.
// RQ11: bits 0, 4 and 8 read one while crystal, main clock or sub crystal oscillates.
// RQ12: fail flags at 9, 5 and 1 read one while pending and a written one clears them.
// RQ13: fail enables at 10, 6 and 2 let their failure raise a pending flag.
// RQ14: with bit 15 clear a main clock failure switches the main select to the ring source.
// RQ15: software enables a source, sees it oscillate and waits for it to settle before use.
// RQ16: a written zero removes a peripheral clock right after the write.
// RQ17: a watched clock with no edge within a window of ring edges is declared failed.
`include "csm_regs.vh"

module csm_clock_ctrl (
   input  wire        clk_sys,
   input  wire        reset_n,
   // axi4-lite write address and data
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // oscillator pins seen by the monitor
   input  wire        ring_clk_in,
   input  wire        crystal_clk_in,
   input  wire        sub_crystal_clk_in,
   input  wire        main_clk_in,
   // clock tree controls
   output reg  [31:0] periph_clk_en_r,
   output reg         sub_crystal_enable_r,
   output reg         ring_enable_r,
   output reg         ring_div2_r,
   output reg         internal_rc_enable_r,
   output reg         internal_rc_div2_r,
   output reg         crystal_enable_r,
   output reg         crystal_div2_r,
   output reg         pll_reference_select_r,
   output reg  [1:0]  main_clock_select_r,
   output reg         clock_fail_pending_r
);

   reg [31:0] gate_two_r;
   reg [7:0]  src_ctrl_r;
   reg [7:0]  sys_sel_r;
   reg [15:0] mon_ctrl_r;
   reg        sub_fail_flag_r;
   reg        main_fail_flag_r;
   reg        crystal_fail_flag_r;
   reg        ring_sync1_r;
   reg        ring_sync2_r;
   reg        ring_sync3_r;
   reg [31:0] rd_word;
   reg        rd_hit;
   wire       ring_tick;
   wire       crystal_running;
   wire       main_clock_running;
   wire       sub_crystal_running;
   wire       crystal_fail_evt;
   wire       main_fail_evt;
   wire       sub_fail_evt;
   wire       wr_fire;
   wire       wr_hit;
   wire [31:0] wr_merge_gate;
   wire [31:0] wr_merge_src;
   wire [31:0] wr_merge_sel;
   wire [31:0] wr_merge_mon;
   wire [31:0] clear_mask;
   wire       main_recover;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // byte-lane merge of write data into an old word, restricted to writable bits
   function [31:0] lane_merge;
      input [31:0] old_word;
      input [31:0] new_word;
      input [3:0]  strb;
      input [31:0] wmask;
      integer      i;
      reg   [31:0] m;
      begin
         m = 32'h00000000;
         for (i = 0; i < 4; i = i + 1)
            m[i*8 +: 8] = {8{strb[i]}};
         m = m & wmask;
         lane_merge = (old_word & ~m) | (new_word & m);
      end
   endfunction

   // address decode shared by write and read
   function addr_mapped;
      input [31:0] a;
      begin
         addr_mapped = (a == `CSM_ADDR_GATE_TWO) || (a == `CSM_ADDR_SRC_CTRL) ||
                       (a == `CSM_ADDR_SYS_SEL)  || (a == `CSM_ADDR_MONITOR);
      end
   endfunction

   // ****************************************************************
   // ring reference synchroniser
   // ****************************************************************
   // ring edges pace the fail windows, so the ring itself is never judged
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ring_sync1_r <= 1'b0;
         ring_sync2_r <= 1'b0;
         ring_sync3_r <= 1'b0;
      end else begin
         ring_sync1_r <= ring_clk_in;
         ring_sync2_r <= ring_sync1_r;
         ring_sync3_r <= ring_sync2_r;
      end
   end

   assign ring_tick = ring_sync2_r ^ ring_sync3_r;

   // ****************************************************************
   // watchdogs for crystal, main clock and sub crystal
   // ****************************************************************
   csm_clk_watch u_watch_crystal (
      .clk_sys      (clk_sys),
      .reset_n      (reset_n),
      .watch_clk    (crystal_clk_in),
      .ring_tick    (ring_tick),
      .watch_en     (mon_ctrl_r[`CSM_XTAL_WATCH_BIT]),
      .running_r    (crystal_running),
      .fail_pulse_r (crystal_fail_evt)
   );

   csm_clk_watch u_watch_main (
      .clk_sys      (clk_sys),
      .reset_n      (reset_n),
      .watch_clk    (main_clk_in),
      .ring_tick    (ring_tick),
      .watch_en     (mon_ctrl_r[`CSM_MAIN_WATCH_BIT]),
      .running_r    (main_clock_running),
      .fail_pulse_r (main_fail_evt)
   );

   csm_clk_watch u_watch_sub (
      .clk_sys      (clk_sys),
      .reset_n      (reset_n),
      .watch_clk    (sub_crystal_clk_in),
      .ring_tick    (ring_tick),
      .watch_en     (mon_ctrl_r[`CSM_SUB_WATCH_BIT]),
      .running_r    (sub_crystal_running),
      .fail_pulse_r (sub_fail_evt)
   );

   // ****************************************************************
   // write channel
   // ****************************************************************
   // both channels are taken on one edge; the slave waits for the later of the two
   assign wr_fire       = s_axi_awready && s_axi_awvalid && s_axi_wready && s_axi_wvalid;
   assign wr_hit        = addr_mapped(s_axi_awaddr);
   assign wr_merge_gate = lane_merge(gate_two_r, s_axi_wdata, s_axi_wstrb, `CSM_GATE_TWO_MASK);
   assign wr_merge_src  = lane_merge({24'h000000, src_ctrl_r}, s_axi_wdata, s_axi_wstrb,
                                     {24'h000000, `CSM_SRC_CTRL_MASK});
   assign wr_merge_sel  = lane_merge({24'h000000, sys_sel_r}, s_axi_wdata, s_axi_wstrb,
                                     {24'h000000, `CSM_SYS_SEL_MASK});
   assign wr_merge_mon  = lane_merge({16'h0000, mon_ctrl_r}, s_axi_wdata, s_axi_wstrb,
                                     {16'h0000, `CSM_MON_CTRL_MASK});
   // write-one-to-clear lanes for the fail flags
   assign clear_mask    = (wr_fire && s_axi_awaddr == `CSM_ADDR_MONITOR) ?
                          lane_merge(32'h00000000, s_axi_wdata, s_axi_wstrb, 32'hffffffff) : 32'h00000000;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `CSM_RESP_OKAY;
      end else begin
         s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `CSM_RESP_OKAY : `CSM_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // control registers
   // ****************************************************************
   // a main clock failure only switches the main select to the ring source while recovery is not disabled
   assign main_recover = main_fail_evt && !mon_ctrl_r[`CSM_REC_DIS_BIT];

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         gate_two_r <= `CSM_GATE_TWO_RST;
         src_ctrl_r <= `CSM_SRC_CTRL_RST;
         sys_sel_r  <= `CSM_SYS_SEL_RST;
         mon_ctrl_r <= `CSM_MON_CTRL_RST;
      end else begin
         if (wr_fire && s_axi_awaddr == `CSM_ADDR_GATE_TWO)
            gate_two_r <= wr_merge_gate;                              // RQ2
         if (wr_fire && s_axi_awaddr == `CSM_ADDR_SRC_CTRL)
            src_ctrl_r <= wr_merge_src[7:0];
         if (wr_fire && s_axi_awaddr == `CSM_ADDR_MONITOR)
            mon_ctrl_r <= wr_merge_mon[15:0];
         // hardware recovery wins over a software write in the same cycle
         if (main_recover)
            sys_sel_r <= {sys_sel_r[7:2], `CSM_MCLK_RING};            // RQ14
         else if (wr_fire && s_axi_awaddr == `CSM_ADDR_SYS_SEL)
            sys_sel_r <= wr_merge_sel[7:0];
      end
   end

   // ****************************************************************
   // fail flags
   // ****************************************************************
   // a new failure in the clearing cycle keeps the flag set
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sub_fail_flag_r     <= 1'b0;
         main_fail_flag_r    <= 1'b0;
         crystal_fail_flag_r <= 1'b0;
      end else begin
         if (sub_fail_evt && mon_ctrl_r[`CSM_SUB_IE_BIT])             // RQ13
            sub_fail_flag_r <= 1'b1;
         else if (clear_mask[`CSM_SUB_FAIL_BIT])
            sub_fail_flag_r <= 1'b0;                                  // RQ12
         if (main_fail_evt && mon_ctrl_r[`CSM_MAIN_IE_BIT])           // RQ13
            main_fail_flag_r <= 1'b1;
         else if (clear_mask[`CSM_MAIN_FAIL_BIT])
            main_fail_flag_r <= 1'b0;                                 // RQ12
         if (crystal_fail_evt && mon_ctrl_r[`CSM_XTAL_IE_BIT])        // RQ13
            crystal_fail_flag_r <= 1'b1;
         else if (clear_mask[`CSM_XTAL_FAIL_BIT])
            crystal_fail_flag_r <= 1'b0;                              // RQ12
      end
   end

   // ****************************************************************
   // read channel
   // ****************************************************************
   always @* begin
      rd_word = 32'h00000000;
      rd_hit  = addr_mapped(s_axi_araddr);
      case (s_axi_araddr)
         `CSM_ADDR_GATE_TWO : rd_word = gate_two_r;
         `CSM_ADDR_SRC_CTRL : rd_word = {24'h000000, src_ctrl_r};
         `CSM_ADDR_SYS_SEL  : rd_word = {24'h000000, sys_sel_r};
         `CSM_ADDR_MONITOR  : begin
            rd_word[15:0]                = mon_ctrl_r;
            rd_word[`CSM_SUB_FAIL_BIT]   = sub_fail_flag_r;           // RQ12
            rd_word[`CSM_MAIN_FAIL_BIT]  = main_fail_flag_r;          // RQ12
            rd_word[`CSM_XTAL_FAIL_BIT]  = crystal_fail_flag_r;       // RQ12
            rd_word[`CSM_SUB_RUN_BIT]    = sub_crystal_running;       // RQ10
            rd_word[`CSM_MAIN_RUN_BIT]   = main_clock_running;        // RQ11
            rd_word[`CSM_XTAL_RUN_BIT]   = crystal_running;           // RQ11
         end
         default            : rd_word = 32'h00000000;
      endcase
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `CSM_RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arready && s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `CSM_RESP_OKAY : `CSM_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // clock tree outputs
   // ****************************************************************
   // one cycle after the write; the enable feeds a glitch-free gate cell outside
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         periph_clk_en_r        <= `CSM_GATE_TWO_RST;
         sub_crystal_enable_r   <= 1'b0;
         ring_enable_r          <= 1'b1;
         ring_div2_r            <= 1'b0;
         internal_rc_enable_r   <= 1'b0;
         internal_rc_div2_r     <= 1'b0;
         crystal_enable_r       <= 1'b0;
         crystal_div2_r         <= 1'b0;
         pll_reference_select_r <= 1'b0;
         main_clock_select_r    <= `CSM_MCLK_RING;
         clock_fail_pending_r   <= 1'b0;
      end else begin
         periph_clk_en_r        <= gate_two_r;                                         // RQ1 RQ16
         sub_crystal_enable_r   <= src_ctrl_r[`CSM_SUB_EN_BIT];                        // RQ3
         ring_enable_r          <= src_ctrl_r[`CSM_RING_EN_BIT];                       // RQ4
         ring_div2_r            <= src_ctrl_r[`CSM_RING_EN_BIT] && src_ctrl_r[`CSM_RING_DIV_BIT];
         internal_rc_enable_r   <= src_ctrl_r[`CSM_IRC_EN_BIT];                        // RQ5
         internal_rc_div2_r     <= src_ctrl_r[`CSM_IRC_EN_BIT] && src_ctrl_r[`CSM_IRC_DIV_BIT];
         crystal_enable_r       <= src_ctrl_r[`CSM_XTAL_EN_BIT];                       // RQ6
         crystal_div2_r         <= src_ctrl_r[`CSM_XTAL_EN_BIT] && src_ctrl_r[`CSM_XTAL_DIV_BIT];
         pll_reference_select_r <= sys_sel_r[`CSM_PLL_REF_BIT];                        // RQ7
         // 0X collapses to 00 so the tree sees only three codes
         main_clock_select_r    <= sys_sel_r[`CSM_MCLK_SEL_HI] ?
                                   sys_sel_r[`CSM_MCLK_SEL_HI:`CSM_MCLK_SEL_LO] : `CSM_MCLK_RING; // RQ8
         clock_fail_pending_r   <= sub_fail_flag_r || main_fail_flag_r || crystal_fail_flag_r;
      end
   end

endmodule // csm_clock_ctrl

// ===== dv/csm_sva.sv
// assertion checker on the block's ports
module csm_sva (
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] periph_clk_en_r,
   input wire logic        ring_enable_r,
   input wire logic        ring_div2_r,
   input wire logic        internal_rc_enable_r,
   input wire logic        internal_rc_div2_r,
   input wire logic        crystal_enable_r,
   input wire logic        crystal_div2_r,
   input wire logic [1:0]  main_clock_select_r,
   input wire logic        clock_fail_pending_r
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   AST_GATE_BITS: assert property ((periph_clk_en_r & ~32'h00330f33) == 32'h0)
      else $error("gate bit off the map");
   AST_RING_DIV: assert property (ring_div2_r |-> ring_enable_r)
      else $error("ring divider without ring enable");
   AST_IRC_DIV: assert property (internal_rc_div2_r |-> internal_rc_enable_r)
      else $error("rc divider without rc enable");
   AST_XTAL_DIV: assert property (crystal_div2_r |-> crystal_enable_r)
      else $error("crystal divider without crystal enable");
   AST_MSEL_CODE: assert property (main_clock_select_r != 2'b01)
      else $error("main select alias code");
   AST_WR_ANSWER: assert property ($rose(s_axi_awready) |=> s_axi_bvalid && !s_axi_awready)
      else $error("write answer late");
   AST_RD_ANSWER: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped early");
   AST_PEND_CLR: assert property ($fell(clock_fail_pending_r) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("pending cleared without a write");
endmodule // csm_sva

bind csm_clock_ctrl csm_sva csm_sva_inst (.clk_sys, .reset_n, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .periph_clk_en_r, .ring_enable_r, .ring_div2_r,
   .internal_rc_enable_r, .internal_rc_div2_r, .crystal_enable_r, .crystal_div2_r, .main_clock_select_r,
   .clock_fail_pending_r);

// ===== dv/csm_osc_model.sv
// oscillator pins answering the clock tree controls
module csm_osc_model (
   input  wire logic clk_sys,
   input  wire logic ring_en,
   input  wire logic ring_div2,
   input  wire logic xtal_en,
   input  wire logic sub_en,
   input  wire logic xtal_ok,
   input  wire logic main_ok,
   output logic      ring_clk = 1'b0,
   output logic      xtal_clk = 1'b0,
   output logic      sub_clk  = 1'b0,
   output logic      main_clk = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int n = 0;
   // slow phases against aliasing; xtal_ok stops both crystals
   always @(posedge clk_sys) begin
      n <= n + 1;
      if (ring_en && n % (ring_div2 ? 12 : 6) == 0) ring_clk <= !ring_clk;
      if (xtal_en && xtal_ok && n % 5 == 0) xtal_clk <= !xtal_clk;
      if (sub_en && xtal_ok && n % 7 == 0) sub_clk <= !sub_clk;
      if (main_ok && n % 4 == 0) main_clk <= !main_clk;
   end
endmodule // csm_osc_model

// ===== dv/test_csm_clock_ctrl.sv
// self-checking bench for the clock control block
`include "csm_regs.vh"
module test_csm_clock_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 0, reset_n = 0, xtal_ok = 1, main_ok = 1;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, periph_clk_en_r, d;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, main_clock_select_r;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sub_crystal_enable_r;
   logic        ring_enable_r, ring_div2_r, internal_rc_enable_r, internal_rc_div2_r, crystal_enable_r;
   logic        crystal_div2_r, pll_reference_select_r, clock_fail_pending_r;
   logic        ring_clk_in, crystal_clk_in, sub_crystal_clk_in, main_clk_in;
   int          n_fail = 0, total_checks = 0, seed = 32'hb3f5, k;
   logic [31:0] ad[5] = '{`CSM_ADDR_GATE_TWO, `CSM_ADDR_SRC_CTRL, `CSM_ADDR_SYS_SEL, `CSM_ADDR_MONITOR, 32'h4000003c};
   int          msk[5] = '{32'h00330f33, 32'hbf, 32'h07, 32'h8ccc, 0};
   int          m[5] = '{32'h101, 32'h20, 0, 0, 0};

   csm_clock_ctrl csm_clock_ctrl_inst (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .ring_clk_in, .crystal_clk_in, .sub_crystal_clk_in, .main_clk_in, .periph_clk_en_r, .sub_crystal_enable_r,
      .ring_enable_r, .ring_div2_r, .internal_rc_enable_r, .internal_rc_div2_r, .crystal_enable_r,
      .crystal_div2_r, .pll_reference_select_r, .main_clock_select_r, .clock_fail_pending_r);
   csm_osc_model csm_osc_model_inst (.clk_sys, .ring_en(ring_enable_r), .ring_div2(ring_div2_r),
      .xtal_en(crystal_enable_r), .sub_en(sub_crystal_enable_r), .xtal_ok, .main_ok, .ring_clk(ring_clk_in),
      .xtal_clk(crystal_clk_in), .sub_clk(sub_crystal_clk_in), .main_clk(main_clk_in));

   // 40 mhz system clock
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // stuck handshake
   task hang;
      n_fail++;
      $display("[ERR] %0t handshake timeout", $time);
      close_out;
   endtask
   // one write; mirror keeps writable bits
   task wr(input int i, input logic [31:0] v);
      @(posedge clk_sys);
      s_axi_awaddr <= ad[i];
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      k = 0;
      do begin @(posedge clk_sys); k++; end while (!(s_axi_awready && s_axi_wready) && k < 64);
      s_axi_awvalid <= 0;
      s_axi_wvalid <= 0;
      do begin @(posedge clk_sys); k++; end while (!s_axi_bvalid && k < 64);
      if (k >= 64) hang;
      chk(s_axi_bresp, i == 4 ? 2'b10 : 2'b00);
      s_axi_bready <= 0;
      m[i] = v & msk[i];
   endtask
   // one read; st adds status bits
   task rd(input int i, input logic [31:0] st);
      @(posedge clk_sys);
      s_axi_araddr <= ad[i];
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      k = 0;
      do begin @(posedge clk_sys); k++; end while (!s_axi_arready && k < 64);
      s_axi_arvalid <= 0;
      do begin @(posedge clk_sys); k++; end while (!s_axi_rvalid && k < 64);
      if (k >= 64) hang;
      chk(s_axi_rdata, m[i] | st);
      chk(s_axi_rresp, i == 4 ? 2'b10 : 2'b00);
      s_axi_rready <= 0;
   endtask

   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      reset_n <= 1;
      @(posedge clk_sys);
      chk(periph_clk_en_r, 32'h101);
      for (int i = 0; i < 5; i++) rd(i, i == 3 ? 32'h111 : 0);
      $display("reset values done");
      for (int j = 0; j < 12; j++) begin
         for (int i = 0; i < 5; i++) begin
            d = $random(seed);
            if (i == 2 && !(m[1][3] && m[1][1])) d[2] = 0;
            if (i == 3) d = d & 32'hfffff777;
            wr(i, d);
         end
         for (int i = 0; i < 5; i++) rd(i, i == 3 ? 32'h111 : 0);
         chk(periph_clk_en_r, m[0]);
         d = m[1];
         chk({sub_crystal_enable_r, ring_enable_r, ring_div2_r, internal_rc_enable_r, internal_rc_div2_r,
            crystal_enable_r, crystal_div2_r}, {d[7], d[5], d[5] & d[4], d[3], d[3] & d[2], d[1], d[1] & d[0]});
         d = m[2];
         chk({pll_reference_select_r, main_clock_select_r}, {d[2], d[1] ? d[1:0] : 2'b00});
      end
      $display("control words done");
      wr(1, 32'ha2);
      wr(2, 0);
      wr(3, 32'h0c0c);
      repeat (100) @(posedge clk_sys);
      rd(3, 32'h111);
      xtal_ok <= 0;
      repeat (200) @(posedge clk_sys);
      rd(3, 32'h212);
      chk(clock_fail_pending_r, 1);
      wr(3, 32'h0e0e);
      rd(3, 32'h010);
      chk(clock_fail_pending_r, 0);
      $display("crystal watch done");
      for (int r = 1; r >= 0; r--) begin
         main_ok <= 1;
         wr(2, 32'h3);
         wr(3, r ? 32'h8080 : 32'h00e0);
         repeat (100) @(posedge clk_sys);
         main_ok <= 0;
         repeat (200) @(posedge clk_sys);
         if (r == 0) m[2] = 0;
         rd(2, 0);
         chk(main_clock_select_r, m[2]);
         rd(3, r ? 32'h101 : 32'h121);
         chk(clock_fail_pending_r, r ? 0 : 1);
         $display("main recovery %0d done", r);
      end
      close_out;
   end
endmodule // test_csm_clock_ctrl
